// ==== src/serial_port_pkg.sv ====
// Purpose: Shared constants for the serial control register port
// Assumes: One 24-bit frame per access, 16-bit registers, 4-bit address
// Notes: Only the main configuration register is implemented

package serial_port_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Frame layout
    localparam int CNT_W = 5;
    localparam int DATA_BITS = 16;
    localparam int CMD_BITS_N = 8;
    localparam int ADDR_W = 4;
    localparam logic [CNT_W-1:0] CMD_BITS = 5'h08;
    localparam logic [CNT_W-1:0] FRAME_BITS = 5'h18;
    localparam logic [CNT_W-1:0] LAST_BIT = 5'h17;

    // Positions inside the eight command bits, first bit received at the top
    localparam int CMD_RW_POS = 7;
    localparam int CMD_ADDR_MSB = 4;
    localparam int CMD_ADDR_LSB = 1;

    ////////////////////////////////////////////////////////////////////////////
    // Register map
    localparam logic [ADDR_W-1:0] MAIN_CONFIGURATION_ADDR = 4'h0;

    // Field positions of main_configuration
    localparam int CFG_CAL_POS = 15;
    localparam int CFG_DATA_CLK_QUADRATURE_POS = 14;
    localparam int CFG_SWING_SELECT_POS = 13;
    localparam int CFG_PATTERN_OUT_SEL_POS = 12;
    localparam int CFG_I_CHAN_SLEEP_POS = 11;
    localparam int CFG_Q_CHAN_SLEEP_POS = 10;
    localparam int CFG_DUAL_EDGE_POS = 7;
    localparam int CFG_TWOS_COMP_FMT_POS = 4;

    // Reset value: higher swing selected, every other field cleared
    localparam logic [DATA_BITS-1:0] MAIN_CONFIGURATION_RESET = 16'h2000;
    localparam logic [DATA_BITS-1:0] UNMAPPED_READ_VALUE = 16'h0000;

    // Output value of the swing select outside extended mode
    localparam logic SWING_HIGHER = 1'b1;

    // Pin group positions in the pin synchroniser
    localparam int PIN_W = 5;
    localparam int PIN_ECE_POS = 4;
    localparam int PIN_CAL_POS = 3;
    localparam int PIN_PDI_POS = 2;
    localparam int PIN_PDQ_POS = 1;
    localparam int PIN_PAT_POS = 0;
    localparam logic [PIN_W-1:0] PIN_RESET = 5'h10;

endpackage : serial_port_pkg

// ==== src/level_sync.sv ====
// Purpose: Two flip-flop synchroniser for quasi-static levels
// Assumes: Each bit changes rarely relative to the destination clock
// Notes: First stage feeds only the second stage

`timescale 1ns/10ps
`default_nettype none

module level_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    // Destination clock and reset
    input wire logic clk_i,
    input wire logic nrst_i,
    // Levels
    input wire logic [WIDTH-1:0] d_i,
    output logic [WIDTH-1:0] q_o
);

    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] stable_q;

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            meta_q <= RESET_VAL;
            stable_q <= RESET_VAL;
        end else begin
            meta_q <= d_i;
            stable_q <= meta_q;
        end
    end

    assign q_o = stable_q;

endmodule : level_sync

`default_nettype wire

// ==== src/serial_out_stage.sv ====
// Purpose: Falling-edge shifter and enable for the serial reply line
// Assumes: Load and shift strobes come from the rising-edge frame logic
// Notes: Select high forces the line undriven without any clock edge

`timescale 1ns/10ps
`default_nettype none

module serial_out_stage (
    // Link clock and select
    input wire logic sclk_i,
    input wire logic serial_select_n_i,
    // Controls from frame logic
    input wire logic load_i,
    input wire logic shift_i,
    input wire logic [serial_port_pkg::DATA_BITS-1:0] load_data_i,
    // Line
    output logic serial_out_line_o,
    output logic serial_out_line_oe_n_o
);

    logic [serial_port_pkg::DATA_BITS-1:0] shift_q;
    logic oe_n_q;

    always_ff @(negedge sclk_i or posedge serial_select_n_i) begin
        if (serial_select_n_i) begin
            oe_n_q <= 1'b1;
        end else if (load_i) begin
            oe_n_q <= 1'b0;
        end
    end

    always_ff @(negedge sclk_i or posedge serial_select_n_i) begin
        if (serial_select_n_i) begin
            shift_q <= '0;
        end else if (load_i) begin
            shift_q <= load_data_i;
        end else if (shift_i) begin
            shift_q <= {shift_q[serial_port_pkg::DATA_BITS-2:0], 1'b0};
        end
    end

    assign serial_out_line_o = shift_q[serial_port_pkg::DATA_BITS-1];
    assign serial_out_line_oe_n_o = oe_n_q;

endmodule : serial_out_stage

`default_nettype wire

// ==== src/serial_control_register_port.sv ====
// Purpose: Serial register access port and main configuration control outputs
// Assumes: Host keeps the link clock low between frames and toggles select
// Notes: Frame logic runs on the link clock, control outputs on mclk_i
//
// Summary of operation
// - Inputs sampled on link clock rising edge, reply changes on falling edge.
// - Reply driven only while selected, after eight command bits, on reads.
// - Read data goes out MSB first from the eighth falling edge.
// - Deasserting select returns the reply line to undriven.
// - Reads of unimplemented addresses return all zeros.
// - Frame bit 1 high means read, low means write.
// - Frame bits 4 to 7 carry the address, MSB first.
// - Frame bit 8 is ignored.
// - Frame bits 9 to 24 carry the 16-bit data word.
// - Config bit 7 selects dual-edge sampling, default off.
// - Config bit 14 selects data-to-clock phase, default zero degrees.
// - Config bit 13 selects output swing, default higher amplitude.
// - Config bit 4 selects two's complement, default offset binary.
// - Config bit 12 selects test pattern, default off; pin ignored extended.
// - Config bit 15 requests calibration, default zero; pin stays active.
// - Config bits 11 and 10 sleep I and Q; pins stay active.
// - Select released before 24th clock means no access; toggle between frames.
// - Select held past 24 clocks on read keeps last data bit.
// - Extended enable pin high resets all control registers to defaults.
// - Effective calibration request is pin OR register bit in extended mode.

`timescale 1ns/10ps
`default_nettype none

module serial_control_register_port (
    // Core clock and reset
    input wire logic mclk_i,
    input wire logic nrst_i,
    // Serial link
    input wire logic sclk_i,
    input wire logic serial_select_n_i,
    input wire logic serial_in_line_i,
    output logic serial_out_line_o,
    output logic serial_out_line_oe_n_o,
    // Control pins
    input wire logic ext_ctrl_enable_n_i,
    input wire logic cal_pin_i,
    input wire logic i_chan_sleep_pin_i,
    input wire logic q_chan_sleep_pin_i,
    input wire logic pattern_pin_i,
    // Effective control outputs
    output logic extended_ctrl_mode_o,
    output logic dual_edge_o,
    output logic data_clk_quadrature_o,
    output logic swing_select_o,
    output logic twos_comp_fmt_o,
    output logic pattern_out_sel_o,
    output logic cal_request_o,
    output logic i_chan_sleep_o,
    output logic q_chan_sleep_o
);

    ////////////////////////////////////////////////////////////////////////////
    // Declarations

    // Link domain
    logic [serial_port_pkg::CNT_W-1:0] bit_cnt_q;
    logic [serial_port_pkg::CMD_BITS_N-1:0] cmd_q;
    logic [serial_port_pkg::DATA_BITS-1:0] data_q;
    logic [serial_port_pkg::DATA_BITS-1:0] main_configuration_q;
    logic [serial_port_pkg::DATA_BITS-1:0] read_word;
    logic [serial_port_pkg::ADDR_W-1:0] frame_addr;
    logic frame_is_read;
    logic write_fire;
    logic out_load;
    logic out_shift;
    logic clear_meta_q;
    logic link_clear_q;

    // Core domain
    logic [serial_port_pkg::PIN_W-1:0] pins_raw;
    logic [serial_port_pkg::PIN_W-1:0] pins_sync;
    logic [serial_port_pkg::DATA_BITS-1:0] cfg_sync;
    logic cfg_clear_q;
    logic extended_ctrl_mode;
    logic extended_ctrl_mode_q;
    logic dual_edge_q;
    logic data_clk_quadrature_q;
    logic swing_select_q;
    logic twos_comp_fmt_q;
    logic pattern_out_sel_q;
    logic cal_request_q;
    logic i_chan_sleep_q;
    logic q_chan_sleep_q;

    ////////////////////////////////////////////////////////////////////////////
    // Frame bit counter
    // Select high clears it at once; no link clock edge is needed while idle

    always_ff @(posedge sclk_i or posedge serial_select_n_i) begin
        if (serial_select_n_i) begin
            bit_cnt_q <= '0;
        end else if (bit_cnt_q != serial_port_pkg::FRAME_BITS) begin
            bit_cnt_q <= bit_cnt_q + 5'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Command and data capture

    always_ff @(posedge sclk_i or posedge serial_select_n_i) begin
        if (serial_select_n_i) begin
            cmd_q <= '0;
        end else if (bit_cnt_q < serial_port_pkg::CMD_BITS) begin
            cmd_q <= {cmd_q[serial_port_pkg::CMD_BITS_N-2:0], serial_in_line_i};
        end
    end

    always_ff @(posedge sclk_i or posedge serial_select_n_i) begin
        if (serial_select_n_i) begin
            data_q <= '0;
        end else if (bit_cnt_q >= serial_port_pkg::CMD_BITS &&
                     bit_cnt_q < serial_port_pkg::FRAME_BITS) begin
            data_q <= {data_q[serial_port_pkg::DATA_BITS-2:0], serial_in_line_i};
        end
    end

    // Reserved bits and bit 8 are not checked
    assign frame_is_read = cmd_q[serial_port_pkg::CMD_RW_POS];
    assign frame_addr = cmd_q[serial_port_pkg::CMD_ADDR_MSB:serial_port_pkg::CMD_ADDR_LSB];

    ////////////////////////////////////////////////////////////////////////////
    // Clear release into the link domain
    // Raised at once, dropped only after two link clock rises

    always_ff @(posedge sclk_i or posedge cfg_clear_q) begin
        if (cfg_clear_q) begin
            clear_meta_q <= 1'b1;
            link_clear_q <= 1'b1;
        end else begin
            clear_meta_q <= 1'b0;
            link_clear_q <= clear_meta_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Main configuration register
    // Write lands on the 24th rising edge with the final bit taken live

    assign write_fire = (bit_cnt_q == serial_port_pkg::LAST_BIT) && !frame_is_read &&
                        (frame_addr == serial_port_pkg::MAIN_CONFIGURATION_ADDR);

    always_ff @(posedge sclk_i or posedge link_clear_q) begin
        if (link_clear_q) begin
            main_configuration_q <= serial_port_pkg::MAIN_CONFIGURATION_RESET;
        end else if (write_fire) begin
            main_configuration_q <= {data_q[serial_port_pkg::DATA_BITS-2:0],
                                     serial_in_line_i};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read path

    always_comb begin
        if (frame_addr == serial_port_pkg::MAIN_CONFIGURATION_ADDR) begin
            read_word = main_configuration_q;
        end else begin
            read_word = serial_port_pkg::UNMAPPED_READ_VALUE;
        end
    end

    // Load on the eighth falling edge, shift through the 23rd, then hold
    assign out_load = (bit_cnt_q == serial_port_pkg::CMD_BITS) && frame_is_read;
    assign out_shift = (bit_cnt_q > serial_port_pkg::CMD_BITS) &&
                       (bit_cnt_q < serial_port_pkg::FRAME_BITS);

    serial_out_stage u_out_stage (
        .sclk_i(sclk_i),
        .serial_select_n_i(serial_select_n_i),
        .load_i(out_load),
        .shift_i(out_shift),
        .load_data_i(read_word),
        .serial_out_line_o(serial_out_line_o),
        .serial_out_line_oe_n_o(serial_out_line_oe_n_o)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Crossings into the core domain

    assign pins_raw = {ext_ctrl_enable_n_i, cal_pin_i, i_chan_sleep_pin_i,
                       q_chan_sleep_pin_i, pattern_pin_i};

    level_sync #(
        .WIDTH(serial_port_pkg::PIN_W),
        .RESET_VAL(serial_port_pkg::PIN_RESET)
    ) u_pin_sync (
        .clk_i(mclk_i),
        .nrst_i(nrst_i),
        .d_i(pins_raw),
        .q_o(pins_sync)
    );

    // Register contents are quasi-static between frames
    level_sync #(
        .WIDTH(serial_port_pkg::DATA_BITS),
        .RESET_VAL(serial_port_pkg::MAIN_CONFIGURATION_RESET)
    ) u_cfg_sync (
        .clk_i(mclk_i),
        .nrst_i(nrst_i),
        .d_i(main_configuration_q),
        .q_o(cfg_sync)
    );

    assign extended_ctrl_mode = !pins_sync[serial_port_pkg::PIN_ECE_POS];

    ////////////////////////////////////////////////////////////////////////////
    // Register clear request
    // Held from core reset and for as long as extended mode is off

    always_ff @(posedge mclk_i) begin
        if (!nrst_i) begin
            cfg_clear_q <= 1'b1;
        end else begin
            cfg_clear_q <= !extended_ctrl_mode;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Effective control outputs

    always_ff @(posedge mclk_i) begin
        if (!nrst_i) begin
            extended_ctrl_mode_q <= 1'b0;
        end else begin
            extended_ctrl_mode_q <= extended_ctrl_mode;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!nrst_i) begin
            dual_edge_q <= 1'b0;
            data_clk_quadrature_q <= 1'b0;
            twos_comp_fmt_q <= 1'b0;
        end else begin
            dual_edge_q <= extended_ctrl_mode && cfg_sync[serial_port_pkg::CFG_DUAL_EDGE_POS];
            data_clk_quadrature_q <= extended_ctrl_mode &&
                cfg_sync[serial_port_pkg::CFG_DATA_CLK_QUADRATURE_POS];
            twos_comp_fmt_q <= extended_ctrl_mode &&
                cfg_sync[serial_port_pkg::CFG_TWOS_COMP_FMT_POS];
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!nrst_i) begin
            swing_select_q <= serial_port_pkg::SWING_HIGHER;
        end else if (extended_ctrl_mode) begin
            swing_select_q <= cfg_sync[serial_port_pkg::CFG_SWING_SELECT_POS];
        end else begin
            swing_select_q <= serial_port_pkg::SWING_HIGHER;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!nrst_i) begin
            pattern_out_sel_q <= 1'b0;
        end else if (extended_ctrl_mode) begin
            pattern_out_sel_q <= cfg_sync[serial_port_pkg::CFG_PATTERN_OUT_SEL_POS];
        end else begin
            pattern_out_sel_q <= pins_sync[serial_port_pkg::PIN_PAT_POS];
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!nrst_i) begin
            cal_request_q <= 1'b0;
        end else begin
            cal_request_q <= pins_sync[serial_port_pkg::PIN_CAL_POS] ||
                (extended_ctrl_mode && cfg_sync[serial_port_pkg::CFG_CAL_POS]);
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!nrst_i) begin
            i_chan_sleep_q <= 1'b0;
            q_chan_sleep_q <= 1'b0;
        end else begin
            i_chan_sleep_q <= pins_sync[serial_port_pkg::PIN_PDI_POS] ||
                (extended_ctrl_mode && cfg_sync[serial_port_pkg::CFG_I_CHAN_SLEEP_POS]);
            q_chan_sleep_q <= pins_sync[serial_port_pkg::PIN_PDQ_POS] ||
                (extended_ctrl_mode && cfg_sync[serial_port_pkg::CFG_Q_CHAN_SLEEP_POS]);
        end
    end

    assign extended_ctrl_mode_o = extended_ctrl_mode_q;
    assign dual_edge_o = dual_edge_q;
    assign data_clk_quadrature_o = data_clk_quadrature_q;
    assign swing_select_o = swing_select_q;
    assign twos_comp_fmt_o = twos_comp_fmt_q;
    assign pattern_out_sel_o = pattern_out_sel_q;
    assign cal_request_o = cal_request_q;
    assign i_chan_sleep_o = i_chan_sleep_q;
    assign q_chan_sleep_o = q_chan_sleep_q;

endmodule : serial_control_register_port

`default_nettype wire

// ==== verif/spi_host_model.sv ====
// Purpose: Serial master model driving frames into the register port
// Assumes: Link clock 6 ns, low between frames, select toggled per frame
// Notes: Released data line shows the reply or the inverse of the last bit

`timescale 1ns/10ps
`default_nettype none

module spi_host_model (
    // Link outputs
    output logic sclk_o,
    output logic select_n_o,
    output logic sdi_o,
    // Reply from device
    input wire logic sdo_i,
    input wire logic sdo_oe_n_i
);
    logic drive_q;
    logic bit_q;

    initial begin
        sclk_o = 1'b0;
        select_n_o = 1'b0;
        drive_q = 1'b1;
        bit_q = 1'b0;
        // Rising select clears the link logic before any frame
        #1 select_n_o = 1'b1;
    end

    // Shared wire once the host lets go
    assign sdi_o = drive_q ? bit_q : (sdo_oe_n_i ? ~bit_q : sdo_i);

    task automatic xfer(input logic rw, input logic [3:0] addr, input logic [15:0] wdata,
        input int nbits, input int extra, output logic [15:0] rdata, output logic held);
        logic [23:0] frame;
        frame = {rw, 2'b10, addr, 1'($urandom), wdata};
        rdata = 'x;
        held = 1'b1;
        select_n_o = 1'b0;
        for (int i = 0; i < nbits + extra; i++) begin
            drive_q = !(rw && i >= 8);
            bit_q = (i < 24) ? frame[23-i] : 1'b0;
            #1.7 sclk_o = 1'b1;
            if (i >= 8 && i < 24) rdata[23-i] = sdo_oe_n_i ? 1'bx : sdo_i;
            if (i >= 24 && (sdo_i !== rdata[0] || sdo_oe_n_i !== 1'b0)) held = 1'b0;
            #3 sclk_o = 1'b0;
            #1.3;
        end
        #1.7 select_n_o = 1'b1;
        drive_q = 1'b1;
        #4;
    endtask : xfer
endmodule : spi_host_model

`default_nettype wire

// ==== verif/serial_port_checker_assertions.sv ====
// Purpose: Port-level checks of the serial register port
// Assumes: Reply enable active low, outputs three mclk edges behind pins
// Notes: Checks on the link clock are disabled while select is high

`timescale 1ns/10ps
`default_nettype none

module serial_port_checker (
    // Clocks and reset
    input wire logic mclk_i,
    input wire logic nrst_i,
    input wire logic sclk_i,
    // Link
    input wire logic serial_select_n_i,
    input wire logic serial_in_line_i,
    input wire logic serial_out_line_o,
    input wire logic serial_out_line_oe_n_o,
    // Pins and controls
    input wire logic ext_ctrl_enable_n_i,
    input wire logic cal_pin_i,
    input wire logic i_chan_sleep_pin_i,
    input wire logic q_chan_sleep_pin_i,
    input wire logic pattern_pin_i,
    input wire logic extended_ctrl_mode_o,
    input wire logic dual_edge_o,
    input wire logic data_clk_quadrature_o,
    input wire logic swing_select_o,
    input wire logic twos_comp_fmt_o,
    input wire logic pattern_out_sel_o,
    input wire logic cal_request_o,
    input wire logic i_chan_sleep_o,
    input wire logic q_chan_sleep_o
);
    logic [4:0] cnt_q;
    logic rd_q;

    // Rising edges seen in this frame, saturating
    always_ff @(posedge sclk_i or posedge serial_select_n_i) begin
        if (serial_select_n_i) cnt_q <= 5'h00;
        else if (cnt_q != 5'h1F) cnt_q <= cnt_q + 5'h01;
    end

    always_ff @(posedge sclk_i or posedge serial_select_n_i) begin
        if (serial_select_n_i) rd_q <= 1'b0;
        else if (cnt_q == 5'h00) rd_q <= serial_in_line_i;
    end

    ////////////////////////////////////////////////////////////////////////////
    a_oe_idle_sel: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        serial_select_n_i |-> serial_out_line_oe_n_o) else $error("reply driven while idle");
    a_oe_after_cmd: assert property (@(negedge sclk_i) disable iff (serial_select_n_i)
        !serial_out_line_oe_n_o |-> cnt_q >= 5'h09 && rd_q) else $error("reply driven early");
    a_oe_on_read: assert property (@(negedge sclk_i) disable iff (serial_select_n_i)
        rd_q && cnt_q >= 5'h09 |-> !serial_out_line_oe_n_o) else $error("read reply missing");
    a_hold_last: assert property (@(negedge sclk_i) disable iff (serial_select_n_i)
        rd_q && cnt_q >= 5'h19 |-> $stable(serial_out_line_o)) else $error("last bit lost");
    a_nonext_fields: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        !extended_ctrl_mode_o |-> swing_select_o && !dual_edge_o && !data_clk_quadrature_o
        && !twos_comp_fmt_o) else $error("non-extended defaults wrong");
    a_ecm_follow: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        (nrst_i && !ext_ctrl_enable_n_i) [*3] |=> extended_ctrl_mode_o)
        else $error("extended mode not entered");
    a_pattern_pin: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        (nrst_i && ext_ctrl_enable_n_i) [*3] |=> pattern_out_sel_o == $past(pattern_pin_i, 3))
        else $error("pattern pin not followed");
    a_cal_pin_or: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        (nrst_i && cal_pin_i) [*3] |=> cal_request_o) else $error("cal pin ignored");
    a_i_sleep_pin: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        (nrst_i && i_chan_sleep_pin_i) [*3] |=> i_chan_sleep_o) else $error("I sleep pin ignored");
    a_q_sleep_pin: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        (nrst_i && q_chan_sleep_pin_i) [*3] |=> q_chan_sleep_o) else $error("Q sleep pin ignored");

    c_read: cover property (@(negedge sclk_i) rd_q && cnt_q == 5'h18);
    c_write: cover property (@(negedge sclk_i) !rd_q && cnt_q == 5'h18);
    c_hold: cover property (@(negedge sclk_i) rd_q && cnt_q >= 5'h19);
    c_nonext: cover property (@(posedge mclk_i) nrst_i && !extended_ctrl_mode_o);
endmodule : serial_port_checker

bind serial_control_register_port serial_port_checker chk_u (.*);

`default_nettype wire

// ==== verif/serial_control_register_port_tb.sv ====
// Purpose: Self-checking bench for the serial register port
// Assumes: Host model drives the link, bench drives pins on mclk_i
// Notes: Random data and pins from a fixed seed

`timescale 1ns/10ps
`default_nettype none

module serial_control_register_port_tb;
    logic mclk_i;
    logic nrst_i;
    logic ext_ctrl_enable_n_i;
    logic [3:0] pins;
    wire logic [8:0] ctrl;
    logic [15:0] cfg;
    logic [15:0] d;
    logic [15:0] rd;
    logic held;
    wire logic sclk;
    wire logic sel_n;
    wire logic serial_in_line;
    wire logic serial_out_line;
    wire logic oe_n;
    int fails;
    int checks_done;

    spi_host_model host_u (.sclk_o(sclk), .select_n_o(sel_n), .sdi_o(serial_in_line), .sdo_i(serial_out_line),
        .sdo_oe_n_i(oe_n));

    serial_control_register_port dut_u (.mclk_i(mclk_i), .nrst_i(nrst_i), .sclk_i(sclk),
        .serial_select_n_i(sel_n), .serial_in_line_i(serial_in_line), .serial_out_line_o(serial_out_line),
        .serial_out_line_oe_n_o(oe_n), .ext_ctrl_enable_n_i(ext_ctrl_enable_n_i),
        .cal_pin_i(pins[3]), .i_chan_sleep_pin_i(pins[2]), .q_chan_sleep_pin_i(pins[1]),
        .pattern_pin_i(pins[0]), .extended_ctrl_mode_o(ctrl[8]), .dual_edge_o(ctrl[7]),
        .data_clk_quadrature_o(ctrl[6]), .swing_select_o(ctrl[5]),
        .twos_comp_fmt_o(ctrl[4]), .pattern_out_sel_o(ctrl[3]), .cal_request_o(ctrl[2]),
        .i_chan_sleep_o(ctrl[1]), .q_chan_sleep_o(ctrl[0]));

    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [8:0] ctrl_exp(input logic [15:0] c, input logic e,
        input logic [3:0] p);
        return {e, e & c[7], e & c[14], e ? c[13] : 1'b1, e & c[4], e ? c[12] : p[0],
            p[3] | (e & c[15]), p[2] | (e & c[11]), p[1] | (e & c[10])};
    endfunction : ctrl_exp

    task automatic cmp_word(input string what, input logic [15:0] exp, input logic [15:0] got);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : cmp_word

    task automatic cmp_ctrl(input logic [8:0] exp);
        checks_done++;
        if (ctrl !== exp) begin
            fails++;
            $display("Error controls expected %h seen %h", exp, ctrl);
        end
    endtask : cmp_ctrl

    task automatic check_ctrl;
        repeat (6) @(posedge mclk_i);
        #1;
        cmp_ctrl(ctrl_exp(cfg, !ext_ctrl_enable_n_i, pins));
    endtask : check_ctrl

    task automatic acc(input logic rw, input logic [3:0] a, input logic [15:0] w, input int n,
        input int extra);
        host_u.xfer(rw, a, w, n, extra, rd, held);
    endtask : acc

    task automatic end_sim;
        if (fails == 0 && checks_done > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : end_sim

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        mclk_i = 1'b0;
        forever #2.5 mclk_i = ~mclk_i;
    end

    // Whole run is about 12 us of frames
    initial begin
        #200us;
        fails++;
        end_sim();
    end

    initial begin
        nrst_i = 1'b0;
        ext_ctrl_enable_n_i = 1'b0;
        pins = 4'h0;
        fails = 0;
        checks_done = 0;
        void'($urandom(32'hF71D7377));
        repeat (20) @(posedge mclk_i);
        nrst_i <= 1'b1;
        repeat (6) @(posedge mclk_i);
        cfg = 16'h2000;
        acc(1'b1, 4'h0, 16'h0000, 24, 0);
        cmp_word("reset config", 16'h2000, rd);
        check_ctrl();
        for (int k = 0; k < 15; k++) begin
            d = (k == 0) ? 16'hFFFF : (k == 1) ? 16'h0000 : 16'($urandom);
            @(posedge mclk_i) pins <= 4'($urandom);
            acc(1'b0, 4'h0, d, 24, 0);
            cfg = d;
            acc(1'b0, 4'(k + 1), ~d, 24, 0);
            acc(1'b0, 4'h0, ~d, 23, 0);
            acc(1'b1, 4'h0, 16'h0000, 24, k % 4);
            cmp_word("config readback", cfg, rd);
            cmp_word("last bit hold", 16'h0001, {15'h0000, held});
            acc(1'b1, 4'(k + 1), 16'h0000, 24, 0);
            cmp_word("unmapped read", 16'h0000, rd);
            check_ctrl();
        end
        @(posedge mclk_i) ext_ctrl_enable_n_i <= 1'b1;
        cfg = 16'h2000;
        check_ctrl();
        acc(1'b0, 4'h0, 16'h5A5A, 24, 0);
        @(posedge mclk_i) ext_ctrl_enable_n_i <= 1'b0;
        check_ctrl();
        acc(1'b1, 4'h0, 16'h0000, 24, 0);
        cmp_word("config after clear", 16'h2000, rd);
        end_sim();
    end
endmodule : serial_control_register_port_tb

`default_nettype wire
